// ---- core/spc_pkg.sv ----
package spc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SERIAL_PORT_CONFIG_OFS   = 12'h000;
    localparam logic [ADDR_W-1:0] READBACK_BANK_SELECT_OFS = 12'h004;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PIN_DIR_BIT    = 7;
    localparam int LSB_FIRST_BIT  = 6;
    localparam int SOFT_RESET_BIT = 5;
    localparam int UNUSED_BIT     = 4;
    localparam int BANK_SEL_BIT   = 0;

    // ------------------------------------------------------------
    // Reset values and address step
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] SERIAL_PORT_CONFIG_RST   = 8'h00;
    localparam logic [DATA_W-1:0] READBACK_BANK_SELECT_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ONE                 = 12'h001;
endpackage

// ---- core/spc_cfg_if.sv ----
`timescale 1ns/10ps
interface spc_cfg_if;
    logic pin_dir;
    logic lsb_first;
    logic i2c_mode;

    modport regs (output pin_dir, output lsb_first, output i2c_mode);
    modport port (input pin_dir, input lsb_first, input i2c_mode);
endinterface

// ---- core/spc_port_ctl.sv ----
`timescale 1ns/10ps
module spc_port_ctl (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    // Configuration
    spc_cfg_if.port                         cfg,
    // Serial engine status
    input  wire logic                       read_phase,
    input  wire logic [spc_pkg::ADDR_W-1:0] cur_addr,
    // Pin control and stepping
    output logic                            sdio_oe_n,
    output logic                            serial_read_out_pin_oe_n,
    output logic                            shift_lsb_first,
    output logic [spc_pkg::ADDR_W-1:0]      next_addr
);
    logic spi_pin_dir;
    logic spi_lsb;

    // Bits 7 and 6 mean nothing on the I2C port
    // I2C gating
    assign spi_pin_dir = cfg.pin_dir & ~cfg.i2c_mode;
    assign spi_lsb     = cfg.lsb_first & ~cfg.i2c_mode;

    // --------------------------------------------------------
    // Data pin drive
    // --------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdio_oe_n                <= 1'b1;
            serial_read_out_pin_oe_n <= 1'b1;
        end else begin
            sdio_oe_n                <= ~(read_phase & ~spi_pin_dir & ~cfg.i2c_mode);
            serial_read_out_pin_oe_n <= ~(read_phase & spi_pin_dir);
        end
    end

    // --------------------------------------------------------
    // Bit order and address stepping
    // --------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_lsb_first <= 1'b0;
            next_addr       <= '0;
        end else begin
            shift_lsb_first <= spi_lsb;
            next_addr       <= spi_lsb ? cur_addr + spc_pkg::ADDR_ONE
                                       : cur_addr - spc_pkg::ADDR_ONE;
        end
    end
endmodule

// ---- core/spc_regs.sv ----
`timescale 1ns/10ps
//
// Contract
// - Bit7 clear: bidirectional pin, output pin released
// - Bit7 set: reads on separate output pin
// - Bit6 clear: MSB first, address decrements
// - Bit6 set: LSB first, address increments
// - I2C mode ignores bits 7 and 6
// - Bit5 write resets registers, self-clears
// - Bank select clear: read buffer bank
// - Bank select set: read active bank
module spc_regs (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    // Port mode from serial engine
    input  wire logic                       i2c_mode,
    input  wire logic                       read_phase,
    // Register access from serial engine
    input  wire logic                       reg_wr_en,
    input  wire logic                       reg_rd_en,
    input  wire logic [spc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [spc_pkg::DATA_W-1:0] reg_wdata,
    output logic      [spc_pkg::DATA_W-1:0] reg_rdata,
    output logic                            reg_rd_valid,
    // Other register banks
    input  wire logic [spc_pkg::DATA_W-1:0] buffer_rdata,
    input  wire logic [spc_pkg::DATA_W-1:0] active_rdata,
    output logic                            soft_reset,
    // Port behaviour
    output logic                            pin_direction_select,
    output logic                            lsb_first,
    output logic                            readback_active,
    output logic                            sdio_oe_n,
    output logic                            serial_read_out_pin_oe_n,
    output logic                            shift_lsb_first,
    output logic [spc_pkg::ADDR_W-1:0]      next_addr
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [spc_pkg::ADDR_W-1:0] a,
                                 input logic [spc_pkg::ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr_cfg;
    logic wr_bank;
    logic soft_req;

    assign wr_cfg   = reg_wr_en & hit(reg_addr, spc_pkg::SERIAL_PORT_CONFIG_OFS);
    assign wr_bank  = reg_wr_en & hit(reg_addr, spc_pkg::READBACK_BANK_SELECT_OFS);
    assign soft_req = wr_cfg & reg_wdata[spc_pkg::SOFT_RESET_BIT];

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Bits 7 and 6 are taken as written unless bit 5 is set; the mirror nibble only
    // exists so the byte decodes the same in either bit order.
    // mirror nibble unused
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_direction_select <= spc_pkg::SERIAL_PORT_CONFIG_RST[spc_pkg::PIN_DIR_BIT];
            lsb_first            <= spc_pkg::SERIAL_PORT_CONFIG_RST[spc_pkg::LSB_FIRST_BIT];
        end else if (soft_req) begin
            pin_direction_select <= spc_pkg::SERIAL_PORT_CONFIG_RST[spc_pkg::PIN_DIR_BIT];
            lsb_first            <= spc_pkg::SERIAL_PORT_CONFIG_RST[spc_pkg::LSB_FIRST_BIT];
        end else if (wr_cfg) begin
            pin_direction_select <= reg_wdata[spc_pkg::PIN_DIR_BIT];
            lsb_first            <= reg_wdata[spc_pkg::LSB_FIRST_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            readback_active <= spc_pkg::READBACK_BANK_SELECT_RST[spc_pkg::BANK_SEL_BIT];
        end else if (soft_req) begin
            readback_active <= spc_pkg::READBACK_BANK_SELECT_RST[spc_pkg::BANK_SEL_BIT];
        end else if (wr_bank) begin
            readback_active <= reg_wdata[spc_pkg::BANK_SEL_BIT];
        end
    end

    // Pulse to the other banks; bit never holds so it self-clears
    // one-cycle reset pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= soft_req;
        end
    end

    // ------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------
    logic [spc_pkg::DATA_W-1:0] cfg_view;

    // Bits 7:6 read zero in I2C mode; bit 4 and its mirror zero
    always_comb begin
        cfg_view = '0;
        cfg_view[spc_pkg::PIN_DIR_BIT]   = pin_direction_select & ~i2c_mode;
        cfg_view[spc_pkg::LSB_FIRST_BIT] = lsb_first & ~i2c_mode;
        cfg_view[spc_pkg::UNUSED_BIT]    = 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg_view[i] = cfg_view[7-i];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata    <= '0;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                if (hit(reg_addr, spc_pkg::SERIAL_PORT_CONFIG_OFS)) begin
                    reg_rdata <= cfg_view;
                end else if (hit(reg_addr, spc_pkg::READBACK_BANK_SELECT_OFS)) begin
                    reg_rdata <= {7'h00, readback_active};
                end else if (readback_active) begin
                    reg_rdata <= active_rdata;
                end else begin
                    reg_rdata <= buffer_rdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin and stepping control
    // ------------------------------------------------------------
    spc_cfg_if cfg_bus ();

    assign cfg_bus.pin_dir   = pin_direction_select;
    assign cfg_bus.lsb_first = lsb_first;
    assign cfg_bus.i2c_mode  = i2c_mode;

    spc_port_ctl u_port_ctl (
        .core_clk                 (core_clk),
        .rst_n                    (rst_n),
        .cfg                      (cfg_bus),
        .read_phase               (read_phase),
        .cur_addr                 (reg_addr),
        .sdio_oe_n                (sdio_oe_n),
        .serial_read_out_pin_oe_n (serial_read_out_pin_oe_n),
        .shift_lsb_first          (shift_lsb_first),
        .next_addr                (next_addr)
    );
endmodule

// ---- testbench/spc_regs_asserts.sv ----
`timescale 1ns/10ps
module spc_regs_asserts (
    input wire logic        core_clk, reset_n, i2c_mode, read_phase, reg_wr_en, reg_rd_en,
    input wire logic [11:0] reg_addr, next_addr,
    input wire logic [7:0]  reg_wdata, reg_rdata, buffer_rdata, active_rdata,
    input wire logic        reg_rd_valid, soft_reset, pin_direction_select, lsb_first,
    input wire logic        readback_active, sdio_oe_n, serial_read_out_pin_oe_n, shift_lsb_first
);
    logic [1:0] up;
    // Outputs are only meaningful after the two-flop release
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd_oth;
        up == 2'h3 && reg_rd_en && reg_addr != 12'h000 && reg_addr != 12'h004;
    endsequence
    sequence s_rd_cfg;
        up == 2'h3 && reg_rd_en && reg_addr == 12'h000;
    endsequence
    sequence s_soft;
        up == 2'h3 && reg_wr_en && reg_addr == 12'h000 && reg_wdata[5];
    endsequence
    chk_buffer_bank: assert property (
        s_rd_oth ##0 !readback_active |=> reg_rdata == $past(buffer_rdata)) else $error("buffer bank");
    chk_active_bank: assert property (
        s_rd_oth ##0 readback_active |=> reg_rdata == $past(active_rdata)) else $error("active bank");
    chk_soft_clear: assert property (
        s_soft |=> soft_reset && !pin_direction_select && !lsb_first && !readback_active
        ##1 !soft_reset) else $error("soft reset");
    chk_unused_zero: assert property (
        s_rd_cfg |=> reg_rdata[5:2] == 4'h0 && reg_rdata[1:0] == {reg_rdata[6], reg_rdata[7]})
        else $error("config readback");
    chk_i2c_cfg_zero: assert property (
        s_rd_cfg ##0 i2c_mode |=> reg_rdata[7:6] == 2'h0) else $error("i2c config bits");
    chk_pin_bidir: assert property (
        up == 2'h3 && read_phase && !pin_direction_select && !i2c_mode
        |=> !sdio_oe_n && serial_read_out_pin_oe_n) else $error("bidir pin");
    chk_pin_unidir: assert property (
        up == 2'h3 && read_phase && pin_direction_select && !i2c_mode
        |=> sdio_oe_n && !serial_read_out_pin_oe_n) else $error("unidir pin");
    chk_step_dec: assert property (
        up == 2'h3 && !(lsb_first && !i2c_mode)
        |=> next_addr == $past(reg_addr) - 12'h001 && !shift_lsb_first) else $error("decrement");
    chk_step_inc: assert property (
        up == 2'h3 && lsb_first && !i2c_mode
        |=> next_addr == $past(reg_addr) + 12'h001 && shift_lsb_first) else $error("increment");
endmodule

bind spc_regs spc_regs_asserts u_chk (.core_clk, .reset_n, .i2c_mode, .read_phase,
    .reg_wr_en, .reg_rd_en, .reg_addr, .next_addr, .reg_wdata, .reg_rdata, .buffer_rdata,
    .active_rdata, .reg_rd_valid, .soft_reset, .pin_direction_select, .lsb_first,
    .readback_active, .sdio_oe_n, .serial_read_out_pin_oe_n, .shift_lsb_first);

// ---- testbench/spc_host.sv ----
`timescale 1ns/10ps
module spc_host (
    input  wire logic   core_clk,
    output logic        reg_wr_en, reg_rd_en, read_phase,
    output logic [11:0] reg_addr,
    output logic [7:0]  reg_wdata, buffer_rdata, active_rdata
);
    initial begin
        {reg_wr_en, reg_rd_en, read_phase} = 3'h0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
    end
    // Distinct bank patterns so a wrong bank shows
    assign buffer_rdata = reg_addr[7:0] ^ 8'hA5;
    assign active_rdata = reg_addr[7:0] ^ 8'h3C;
    task automatic wr(input logic [11:0] a, input logic [3:0] n);
        @(negedge core_clk);
        {reg_wr_en, read_phase} = 2'h2;
        reg_addr = a;
        reg_wdata = {n, n[0], n[1], n[2], n[3]};
        @(negedge core_clk);
        reg_wr_en = 1'h0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(negedge core_clk);
        {reg_rd_en, read_phase} = 2'h3;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd_en = 1'h0;
    endtask
endmodule

// ---- testbench/serial_port_config_regs_test.sv ----
`timescale 1ns/10ps
module serial_port_config_regs_test;
    logic        core_clk = 1'b0, reset_n, i2c_mode;
    logic        reg_wr_en, reg_rd_en, read_phase, reg_rd_valid, soft_reset;
    logic        pin_direction_select, lsb_first, readback_active;
    logic        sdio_oe_n, serial_read_out_pin_oe_n, shift_lsb_first;
    logic [11:0] reg_addr, next_addr;
    logic [7:0]  reg_wdata, reg_rdata, buffer_rdata, active_rdata;
    int          error_cnt = 0, compares = 0, cyc = 0;
    // Nibble, i2c, config readback, effective lsb
    logic [13:0] rows [5] = '{{4'h8, 1'h0, 8'h81, 1'h0}, {4'h4, 1'h0, 8'h42, 1'h1},
        {4'hC, 1'h0, 8'hC3, 1'h1}, {4'hC, 1'h1, 8'h00, 1'h0}, {4'h1, 1'h0, 8'h00, 1'h0}};
    always #5 core_clk = ~core_clk;
    spc_host u_host (.core_clk, .reg_wr_en, .reg_rd_en, .read_phase, .reg_addr,
        .reg_wdata, .buffer_rdata, .active_rdata);
    spc_regs uut (.core_clk, .reset_n, .i2c_mode, .read_phase, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .buffer_rdata, .active_rdata,
        .soft_reset, .pin_direction_select, .lsb_first, .readback_active, .sdio_oe_n,
        .serial_read_out_pin_oe_n, .shift_lsb_first, .next_addr);
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic summarize;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Whole run needs under a hundred cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        reset_n = 1'b0;
        i2c_mode = 1'b0;
        repeat (6) @(negedge core_clk);
        chk("oe_rst", 12'h003, {sdio_oe_n, serial_read_out_pin_oe_n});
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        u_host.rd(12'h000);
        chk("cfg_rst", 12'h000, reg_rdata);
        u_host.rd(12'h004);
        chk("sel_rst", 12'h000, reg_rdata);
        $display("test reset done");
        foreach (rows[i]) begin
            i2c_mode = rows[i][9];
            u_host.wr(12'h000, rows[i][13:10]);
            u_host.rd(12'h000);
            chk("valid", 12'h001, reg_rd_valid);
            chk("cfg", rows[i][8:1], reg_rdata);
            chk("oe", {rows[i][13] | rows[i][9], ~(rows[i][13] & ~rows[i][9])},
                {sdio_oe_n, serial_read_out_pin_oe_n});
            chk("next", rows[i][0] ? 12'h001 : 12'hFFF, next_addr);
            chk("order", rows[i][0], shift_lsb_first);
            chk("pin_dir", rows[i][13], pin_direction_select);
            $display("test row %0d done", i);
        end
        i2c_mode = 1'b0;
        u_host.wr(12'h000, 4'hC);
        u_host.wr(12'h004, 4'h8);
        u_host.wr(12'h000, 4'h2);
        chk("soft", 12'h001, soft_reset);
        chk("cleared", 12'h000, {pin_direction_select, lsb_first, readback_active});
        @(negedge core_clk);
        chk("soft_end", 12'h000, soft_reset);
        $display("test soft reset done");
        u_host.rd(12'h123);
        chk("buffer", 12'h086, reg_rdata);
        chk("next_dec", 12'h122, next_addr);
        u_host.wr(12'h004, 4'h8);
        u_host.rd(12'h123);
        chk("active", 12'h01F, reg_rdata);
        u_host.rd(12'h004);
        chk("sel", 12'h001, reg_rdata);
        $display("test bank select done");
        // Second release in mid-run must bring the defaults back
        u_host.wr(12'h000, 4'hC);
        chk("oe_idle", 12'h003, {sdio_oe_n, serial_read_out_pin_oe_n});
        reset_n = 1'b0;
        @(negedge core_clk);
        chk("oe_mid", 12'h003, {sdio_oe_n, serial_read_out_pin_oe_n});
        chk("cfg_mid", 12'h000, {pin_direction_select, lsb_first, readback_active});
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        u_host.rd(12'h000);
        chk("cfg_again", 12'h000, reg_rdata);
        chk("next_again", 12'hFFF, next_addr);
        $display("test mid reset done");
        summarize();
    end
endmodule
